// File: rtl/dise_params.svh
// constants for the decrement/increment/skip/branch execution block
// assumes inclusion by rtl files only; definitions only
`ifndef DISE_PARAMS_SVH
`define DISE_PARAMS_SVH
`define DISE_OP_DSZ      6'h0b
`define DISE_OP_DSNZ     6'h13
`define DISE_OP_ISZ      6'h0f
`define DISE_OP_INC      6'h0a
`define DISE_OP_DEC      6'h01
`define DISE_OP_BR1      8'hef
`define DISE_OP_BR2      4'hf
`define DISE_OP_DAA      16'h0007
`define DISE_OP_MOVFF    4'hc
`define DISE_OP_CALL_S   8'hec
`define DISE_OP_CALL_F   8'hed
`define DISE_OP_LDPTR    10'h3b8
`define DISE_IDX_MAX     8'h5f
`define DISE_BCD_LIMIT   4'h9
`define DISE_BCD_ADJ     4'h6
`endif

// File: rtl/dise_pkg.sv
// types shared by the execution block
// assumes the params header is included beside it
package dise_pkg;
    typedef enum logic [1:0] {
        DISE_EXEC  = 2'b00,
        DISE_FLUSH = 2'b01,
        DISE_FLUSH2 = 2'b10
    } dise_state_t;
endpackage : dise_pkg

// File: rtl/dise_alu.sv
// combinational arithmetic for the execution block
// assumes operands are valid in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "dise_params.svh"
module dise_alu (
    input  wire logic [7:0] operand,
    input  wire logic       do_inc,
    input  wire logic [7:0] acc,
    input  wire logic       carry_in,
    input  wire logic       dcarry_in,
    output logic      [7:0] result,
    output logic      [7:0] bcd_result,
    output logic            bcd_carry
);
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    // plain +1 / -1 on the file operand
    assign result = do_inc ? operand + 8'h01 : operand - 8'h01;
    // decimal adjust of the accumulator
    always_comb begin
        lo_sum = {1'b0, acc[3:0]};
        if (acc[3:0] > `DISE_BCD_LIMIT || dcarry_in) begin
            lo_sum = {1'b0, acc[3:0]} + {1'b0, `DISE_BCD_ADJ};
        end
        hi_sum = {1'b0, acc[7:4]} + {4'h0, lo_sum[4]};
        if (acc[7:4] > `DISE_BCD_LIMIT || carry_in) begin
            hi_sum = hi_sum + {1'b0, `DISE_BCD_ADJ};
        end
    end
    assign bcd_result = {hi_sum[3:0], lo_sum[3:0]};
    assign bcd_carry  = hi_sum[4] | carry_in;
endmodule : dise_alu
`default_nettype wire

// File: rtl/dise_exec.sv
// execution of dec/inc skip group, absolute branch and decimal adjust tail
// assumes one instruction word per cycle from fetch, file data read combinationally
// Contract
// - decrement file, skip when result zero
// - decrement file, skip when result nonzero
// - taken skip flushes fetched word as no-op
// - destination bit picks accumulator or file
// - access bit picks access bank or bank
// - extended mode indexes low access addresses
// - two-word branch loads counter in the same cycle its second word shows as no-op
// - decimal adjust nibbles by six with carries
`timescale 1ns/1ns
`default_nettype none
`include "dise_params.svh"
module dise_exec #(
    parameter int PC_W = 21
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            instr_valid,
    input  wire logic [15:0]     instr_word,
    input  wire logic            ext_mode,
    input  wire logic [3:0]      bank_select_reg,
    input  wire logic [11:0]     index_base,
    input  wire logic [7:0]      file_rdata,
    input  wire logic [7:0]      acc_in,
    input  wire logic            carry_flag,
    input  wire logic            digit_carry_flag,
    output logic      [11:0]     file_addr_ff,
    output logic                 file_we_ff,
    output logic      [7:0]      file_wdata_ff,
    output logic                 acc_we_ff,
    output logic      [7:0]      acc_wdata_ff,
    output logic                 carry_we_ff,
    output logic                 carry_out_ff,
    output logic                 pc_load_ff,
    output logic      [PC_W-1:0] pc_target_ff,
    output logic                 nop_cycle_ff
);
    // branch target is wired for a 21-bit counter only; other widths are refused
    if (PC_W != 21) begin : g_pc_w_check
        $error("dise_exec: program counter must be 21 bits");
    end

    dise_pkg::dise_state_t state_ff;
    dise_pkg::dise_state_t nxt_state;
    logic [7:0] br_low_ff;
    logic       br_pending_ff;
    logic [7:0] alu_res;
    logic [7:0] bcd_res;
    logic       bcd_c;
    logic       is_dsz;
    logic       is_dsnz;
    logic       is_isz;
    logic       is_inc;
    logic       is_dec;
    logic       is_file_op;
    logic       is_daa;
    logic       is_br1;
    logic       take_skip;
    logic [11:0] eff_addr;

    // two-word opcodes: branch, move-file-to-file, call, load pointer
    // a miss here makes a skip flush one word too few
    function automatic logic first_of_two(input logic [15:0] w);
        logic hit;
        hit = w[15:8] == `DISE_OP_BR1;               // absolute branch
        hit = hit || w[15:12] == `DISE_OP_MOVFF;     // file-to-file move
        hit = hit || w[15:8] == `DISE_OP_CALL_S;     // call, plain return
        hit = hit || w[15:8] == `DISE_OP_CALL_F;     // call, fast return
        hit = hit || w[15:6] == `DISE_OP_LDPTR;      // load pointer, any pointer
        first_of_two = hit;
    endfunction : first_of_two

    // address formation for a byte-oriented operand
    function automatic logic [11:0] file_address(input logic [7:0] f, input logic acc_bit,
                                                 input logic ext, input logic [3:0] bank,
                                                 input logic [11:0] base);
        if (!acc_bit && ext && f <= `DISE_IDX_MAX) begin
            file_address = base + {4'h0, f};
        end else if (!acc_bit) begin
            file_address = f[7] ? {4'hf, f} : {4'h0, f};
        end else begin
            file_address = {bank, f};
        end
    endfunction : file_address

    // decode runs every cycle; only execute state acts on it, and flush state decodes words only as two-word heads or as the branch second word
    assign is_dsz     = instr_word[15:10] == `DISE_OP_DSZ;
    assign is_dsnz    = instr_word[15:10] == `DISE_OP_DSNZ;
    assign is_isz     = instr_word[15:10] == `DISE_OP_ISZ;
    assign is_inc     = instr_word[15:10] == `DISE_OP_INC;
    assign is_dec     = instr_word[15:10] == `DISE_OP_DEC;
    assign is_file_op = is_dsz | is_dsnz | is_isz | is_inc | is_dec;
    assign is_daa     = instr_word == `DISE_OP_DAA;
    assign is_br1     = instr_word[15:8] == `DISE_OP_BR1;
    assign eff_addr   = file_address(instr_word[7:0], instr_word[8], ext_mode, bank_select_reg, index_base);
    // no lookahead from fetch: the flush length is judged from the word that
    // arrives in the first flush cycle, so fetch must not reorder words there

    dise_alu u_alu (
        .operand    (file_rdata),
        .do_inc     (is_isz | is_inc),
        .acc        (acc_in),
        .carry_in   (carry_flag),
        .dcarry_in  (digit_carry_flag),
        .result     (alu_res),
        .bcd_result (bcd_res),
        .bcd_carry  (bcd_c)
    );

    // skip decision from the fresh result
    // increment-and-skip tests for zero like the decrement form
    always_comb begin
        take_skip = 1'b0;
        if (is_dsz || is_isz) begin
            take_skip = alu_res == 8'h00;
        end else if (is_dsnz) begin
            take_skip = alu_res != 8'h00;
        end
    end

    // sequencer: flushes and branch second word
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dise_pkg::DISE_EXEC: begin
                if (instr_valid && (is_file_op && take_skip || is_br1)) begin
                    nxt_state = dise_pkg::DISE_FLUSH;
                end
            end
            // a branch second word never counts as a two-word head
            dise_pkg::DISE_FLUSH: begin
                if (instr_valid && first_of_two(instr_word) && !br_pending_ff) begin
                    nxt_state = dise_pkg::DISE_FLUSH2;
                end else if (instr_valid) begin
                    nxt_state = dise_pkg::DISE_EXEC;
                end
            end
            dise_pkg::DISE_FLUSH2: begin
                if (instr_valid) begin
                    nxt_state = dise_pkg::DISE_EXEC;
                end
            end
            default: nxt_state = dise_pkg::DISE_EXEC;
        endcase
    end

    // state register, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= dise_pkg::DISE_EXEC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // branch low byte held for the second word
    always_ff @(posedge clk) begin
        if (rst) begin
            br_pending_ff <= 1'b0;
            br_low_ff     <= 8'h00;
        end else if (instr_valid && state_ff == dise_pkg::DISE_EXEC && is_br1) begin
            br_pending_ff <= 1'b1;
            br_low_ff     <= instr_word[7:0];
        end else if (instr_valid && state_ff == dise_pkg::DISE_FLUSH) begin
            br_pending_ff <= 1'b0;
        end
    end

    // program counter load on the branch second word
    // target holds except on the word after a branch first word, so the counter side may take it late
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_load_ff   <= 1'b0;
            pc_target_ff <= '0;
        end else begin
            pc_load_ff <= instr_valid && state_ff == dise_pkg::DISE_FLUSH && br_pending_ff
                          && instr_word[15:12] == `DISE_OP_BR2;
            if (instr_valid && br_pending_ff && state_ff == dise_pkg::DISE_FLUSH) begin
                pc_target_ff <= {instr_word[11:0], br_low_ff, 1'b0};
            end
        end
    end

    // no-op marker for flushed cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            nop_cycle_ff <= 1'b0;
        end else begin
            nop_cycle_ff <= instr_valid && state_ff != dise_pkg::DISE_EXEC;
        end
    end

    // destination writes
    // data paths load every cycle; only the write enables are qualified
    always_ff @(posedge clk) begin
        if (rst) begin
            file_addr_ff  <= 12'h000;
            file_we_ff    <= 1'b0;
            file_wdata_ff <= 8'h00;
            acc_we_ff     <= 1'b0;
            acc_wdata_ff  <= 8'h00;
            carry_we_ff   <= 1'b0;
            carry_out_ff  <= 1'b0;
        end else begin
            file_addr_ff  <= eff_addr;
            file_wdata_ff <= alu_res;
            acc_wdata_ff  <= is_daa ? bcd_res : alu_res;
            carry_out_ff  <= bcd_c;
            if (instr_valid && state_ff == dise_pkg::DISE_EXEC) begin
                file_we_ff  <= is_file_op && instr_word[9];
                acc_we_ff   <= is_file_op && !instr_word[9] || is_daa;
                carry_we_ff <= is_daa;
            end else begin
                file_we_ff  <= 1'b0;
                acc_we_ff   <= 1'b0;
                carry_we_ff <= 1'b0;
            end
        end
    end
endmodule : dise_exec
`default_nettype wire

// File: bench/dise_mem.sv
// data memory model beside the execution block
// assumes one-cycle write pulses; decodes low address nibble only
`timescale 1ns/1ns
`default_nettype none
module dise_mem (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  raddr,
    input  wire logic        we,
    input  wire logic [11:0] waddr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem_ff [16];
    // bytes reset to their own index so reads are predictable
    always_ff @(posedge clk) begin
        for (int i = 0; i < 16; i++) begin
            if (rst) begin
                mem_ff[i] <= 8'(i);
            end else if (we && waddr[3:0] == 4'(i)) begin
                mem_ff[i] <= wdata;
            end
        end
    end
    assign rdata = mem_ff[raddr]; // same-cycle read
endmodule : dise_mem
`default_nettype wire

// File: bench/dise_exec_chk.sv
// timing checks on the execution block ports
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module dise_exec_chk #(parameter int PC_W = 21) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            instr_valid,
    input wire logic [15:0]     instr_word,
    input wire logic            ext_mode,
    input wire logic [3:0]      bank_select_reg,
    input wire logic [11:0]     index_base,
    input wire logic [7:0]      file_rdata,
    input wire logic [11:0]     file_addr_ff,
    input wire logic            file_we_ff,
    input wire logic [7:0]      file_wdata_ff,
    input wire logic            acc_we_ff,
    input wire logic [7:0]      acc_wdata_ff,
    input wire logic            pc_load_ff,
    input wire logic [PC_W-1:0] pc_target_ff,
    input wire logic            nop_cycle_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a flushed word shows as nop one cycle after it, so nop gates each check
    a_dsz_skip: assert property (instr_valid && instr_word[15:10] == 6'h0b && file_rdata == 8'h01
        ##1 instr_valid && !nop_cycle_ff |=> nop_cycle_ff) else $error("zero skip missed");
    a_dsnz_skip: assert property (instr_valid && instr_word[15:10] == 6'h13 && file_rdata != 8'h01
        ##1 instr_valid && !nop_cycle_ff |=> nop_cycle_ff) else $error("nonzero skip missed");
    a_flush_two: assert property (nop_cycle_ff && $past(instr_valid) &&
        $past(instr_word[15:8]) == 8'hef && instr_valid |=> nop_cycle_ff) else $error("second word run");
    a_dest_sel: assert property (instr_valid && instr_word[15:10] == 6'h01 |=> nop_cycle_ff ||
        (file_we_ff == $past(instr_word[9]) && acc_we_ff != $past(instr_word[9]))) else $error("bad dest");
    a_dec_value: assert property (instr_valid && instr_word[15:10] == 6'h01 |=> nop_cycle_ff ||
        (file_we_ff ? file_wdata_ff : acc_wdata_ff) == $past(file_rdata) - 8'h01) else $error("bad dec");
    a_bank_sel: assert property (instr_valid && instr_word[15:10] == 6'h01 && instr_word[8] |=>
        nop_cycle_ff || file_addr_ff == {$past(bank_select_reg), $past(instr_word[7:0])}) else $error("bank");
    a_index_addr: assert property (instr_valid && instr_word[15:10] == 6'h01 && !instr_word[8] && ext_mode
        && instr_word[7:0] <= 8'h5f |=> nop_cycle_ff ||
        file_addr_ff == $past(index_base) + {4'h0, $past(instr_word[7:0])}) else $error("index");
    a_branch_load: assert property (instr_valid && instr_word[15:8] == 8'hef ##1 instr_valid &&
        instr_word[15:12] == 4'hf && !nop_cycle_ff |=> pc_load_ff && nop_cycle_ff &&
        pc_target_ff == {$past(instr_word[11:0]), $past(instr_word[7:0], 2), 1'b0}) else $error("branch");
endmodule : dise_exec_chk
bind dise_exec dise_exec_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_mode(ext_mode), .bank_select_reg(bank_select_reg), .index_base(index_base),
    .file_rdata(file_rdata), .file_addr_ff(file_addr_ff), .file_we_ff(file_we_ff), .file_wdata_ff(file_wdata_ff),
    .acc_we_ff(acc_we_ff), .acc_wdata_ff(acc_wdata_ff), .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
    .nop_cycle_ff(nop_cycle_ff));
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the skip group and branch execution
// assumes the memory model reads combinationally
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst, instr_valid, ext_mode, carry_flag, digit_carry_flag, file_we_ff, acc_we_ff;
    logic carry_we_ff, carry_out_ff, pc_load_ff, nop_cycle_ff;
    logic [15:0] instr_word;
    logic [3:0] bank_select_reg;
    logic [11:0] index_base, file_addr_ff;
    logic [7:0] file_rdata, acc_in, file_wdata_ff, acc_wdata_ff;
    logic [20:0] pc_target_ff;
    int n_mismatch = 0;
    int check_count = 0;
    dise_exec #(.PC_W(21)) dise_exec_i (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_mode(ext_mode), .bank_select_reg(bank_select_reg), .index_base(index_base), .file_rdata(file_rdata),
        .acc_in(acc_in), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .file_addr_ff(file_addr_ff),
        .file_we_ff(file_we_ff), .file_wdata_ff(file_wdata_ff), .acc_we_ff(acc_we_ff), .acc_wdata_ff(acc_wdata_ff),
        .carry_we_ff(carry_we_ff), .carry_out_ff(carry_out_ff), .pc_load_ff(pc_load_ff),
        .pc_target_ff(pc_target_ff), .nop_cycle_ff(nop_cycle_ff));
    dise_mem dise_mem_i (.clk(clk), .rst(rst), .raddr(instr_word[3:0]), .we(file_we_ff),
        .waddr(file_addr_ff), .wdata(file_wdata_ff), .rdata(file_rdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // drive one word; outputs of the previous word are settled on return
    task step(input logic v, input logic [15:0] w);
        @(posedge clk);
        instr_valid <= v;
        instr_word <= w;
        #1;
    endtask : step
    task chk(input string n, input logic [20:0] e, input logic [20:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task s_dsz;
        step(1'b1, 16'h2c01);
        step(1'b1, 16'h0000);
        chk("acc_we", 1'b1, acc_we_ff);
        chk("acc_wdata", 8'h00, acc_wdata_ff);
        chk("file_addr", 12'h001, file_addr_ff);
        step(1'b1, 16'h0000);
        chk("nop", 1'b1, nop_cycle_ff);
        step(1'b0, 16'h0000);
        chk("nop", 1'b0, nop_cycle_ff);
    endtask : s_dsz
    // skipped word is a two-word branch, so two flushes follow
    task s_dsnz;
        step(1'b1, 16'h4f05);
        step(1'b1, 16'hef00);
        chk("file_we", 1'b1, file_we_ff);
        chk("file_wdata", 8'h04, file_wdata_ff);
        chk("file_addr", 12'h305, file_addr_ff);
        step(1'b1, 16'hf000);
        chk("nop", 1'b1, nop_cycle_ff);
        step(1'b0, 16'h0000);
        chk("nop", 1'b1, nop_cycle_ff);
        step(1'b0, 16'h0000);
        chk("nop", 1'b0, nop_cycle_ff);
    endtask : s_dsnz
    task s_branch;
        step(1'b1, 16'hef34);
        step(1'b1, 16'hf12a);
        step(1'b0, 16'h0000);
        chk("pc_load", 1'b1, pc_load_ff);
        chk("pc_target", 21'h025468, pc_target_ff);
        chk("nop", 1'b1, nop_cycle_ff);
    endtask : s_branch
    // one high-nibble adjust, then one that adjusts both nibbles
    task s_daa;
        step(1'b1, 16'h0007);
        step(1'b0, 16'h0000);
        chk("acc_we", 1'b1, acc_we_ff);
        chk("acc_wdata", 8'h05, acc_wdata_ff);
        chk("carry_we", 1'b1, carry_we_ff);
        chk("carry", 1'b1, carry_out_ff);
        @(posedge clk);
        acc_in <= 8'hce;
        step(1'b1, 16'h0007);
        step(1'b0, 16'h0000);
        chk("acc_wdata", 8'h34, acc_wdata_ff);
        chk("carry", 1'b1, carry_out_ff);
    endtask : s_daa
    // last indexed address, first direct one, upper access page, bank page
    task s_index;
        @(posedge clk);
        ext_mode <= 1'b1;
        step(1'b1, 16'h065f);
        step(1'b1, 16'h0660);
        chk("file_addr", 12'h15f, file_addr_ff);
        step(1'b1, 16'h0690);
        chk("file_addr", 12'h060, file_addr_ff);
        step(1'b1, 16'h07aa);
        chk("file_addr", 12'hf90, file_addr_ff);
        step(1'b0, 16'h0000);
        chk("file_addr", 12'h3aa, file_addr_ff);
    endtask : s_index
    // increment and skip on a byte left at ff by s_index, then a plain increment
    task s_inc;
        step(1'b1, 16'h3c00);
        step(1'b1, 16'h2800);
        chk("acc_we", 1'b1, acc_we_ff);
        chk("acc_wdata", 8'h00, acc_wdata_ff);
        step(1'b1, 16'h2801);
        chk("nop", 1'b1, nop_cycle_ff);
        step(1'b0, 16'h0000);
        chk("nop", 1'b0, nop_cycle_ff);
        chk("acc_wdata", 8'h02, acc_wdata_ff);
    endtask : s_inc
    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        rst = 1'b1;
        {instr_valid, ext_mode, carry_flag, digit_carry_flag} = 4'h0;
        instr_word = 16'h0000;
        bank_select_reg = 4'h3;
        index_base = 12'h100;
        acc_in = 8'ha5;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        s_dsz;
        s_dsnz;
        s_branch;
        s_daa;
        s_index;
        s_inc;
        end_of_test;
    end
endmodule : tb
`default_nettype wire
